//--- ccrb_pkg.sv
/*
 * package of the codec control register bank: register addresses, field
 * positions, reset values and the encodings of modes and formats.
 * assumes: shared by the register bank, its mode decoder and the mode interface.
 */
package ccrb_pkg;

   // register addresses as the pointer carries them
   localparam logic [6:0] ADDR_IDENT = 7'h01;
   localparam logic [6:0] ADDR_POWER = 7'h02;
   localparam logic [6:0] ADDR_FMODE = 7'h03;
   localparam logic [6:0] ADDR_IFMT = 7'h04;
   localparam logic [6:0] ADDR_MISC = 7'h05;

   // pointer byte
   localparam int PTR_AUTOINC_BIT = 7;
   localparam logic [6:0] PTR_RESET = 7'h01;
   localparam logic PTR_AUTOINC_RESET = 1'b1;

   // reset values
   localparam logic [7:0] POWER_RESET = 8'h01;
   localparam logic [7:0] FMODE_RESET = 8'h00;
   localparam logic [7:0] IFMT_RESET = 8'h40;
   localparam logic [7:0] MISC_RESET = 8'h00;

   // writable bits; the rest are reserved and hold zero
   localparam logic [7:0] POWER_MASK = 8'h6f;
   localparam logic [7:0] FMODE_MASK = 8'hf6;
   localparam logic [7:0] IFMT_MASK = 8'hfd;
   localparam logic [7:0] MISC_MASK = 8'hdf;

   // power control fields
   localparam int PLL_SLEEP_BIT = 6;
   localparam int IN_CONV_SLEEP_BIT = 5;
   localparam int OUT_PAIR_LSB = 1;
   localparam int GLOBAL_SLEEP_BIT = 0;

   // functional mode fields
   localparam int OUT_SPEED_LSB = 6;
   localparam int IN_SPEED_LSB = 4;
   localparam int IN_SERIAL_OUT_BIT = 2;
   localparam int DEEMPH_EN_BIT = 1;

   // interface format fields
   localparam int FORMAT_LSB = 6;
   localparam int IN_LINE_LSB = 4;
   localparam int OUT_LINE_LSB = 2;
   localparam int RJ_SHORT_BIT = 0;

   // misc control fields
   localparam int EXT_SCLK_BIT = 7;
   localparam int RCLK_TRI_BIT = 6;
   localparam int FREEZE_BIT = 4;
   localparam int INTERP_BIT = 3;
   localparam int HPF_HOLD_BIT = 2;
   localparam int OUT_MASTER_BIT = 1;
   localparam int IN_MASTER_BIT = 0;

   typedef enum logic {
      CP_POINTER = 1'b0,
      CP_DATA = 1'b1
   } ccrb_cp_state_t;

   typedef enum logic [1:0] {
      SPD_SINGLE = 2'b00,
      SPD_DOUBLE = 2'b01,
      SPD_QUAD = 2'b10,
      SPD_RSVD = 2'b11
   } ccrb_speed_t;

   typedef enum logic [1:0] {
      SER_LEFT = 2'b00,
      SER_I2S = 2'b01,
      SER_RIGHT = 2'b10,
      SER_RSVD = 2'b11
   } ccrb_serial_t;

   typedef enum logic [1:0] {
      LINE_GENERAL = 2'b00,
      LINE_ONE = 2'b01,
      LINE_TWO = 2'b10,
      LINE_RSVD = 2'b11
   } ccrb_line_t;

   // effective framing of a serial port
   typedef enum logic [2:0] {
      FMT_LEFT = 3'b000,
      FMT_I2S = 3'b001,
      FMT_RIGHT = 3'b010,
      FMT_LINE_ONE = 3'b011,
      FMT_LINE_TWO = 3'b100,
      FMT_RSVD = 3'b111
   } ccrb_fmt_t;

   // rate codes: also used for the detected and forced rate inputs
   typedef enum logic [1:0] {
      DE_NONE = 2'b00,
      DE_32K = 2'b01,
      DE_44K1 = 2'b10,
      DE_48K = 2'b11
   } ccrb_deemph_t;

endpackage

//--- ccrb_mode_if.sv
/*
 * interface between the register bank and its mode decoder.
 * assumes: both ends run on the one control clock.
 */
`timescale 1ns/1ps
interface ccrb_mode_if;
   logic deemph_enable;
   logic [1:0] serial_format;
   logic [1:0] in_single_line;
   logic [1:0] out_single_line;
   ccrb_pkg::ccrb_deemph_t deemph_mode;
   ccrb_pkg::ccrb_fmt_t in_frame_format;
   ccrb_pkg::ccrb_fmt_t out_frame_format;

   modport cfg (
      output deemph_enable,
      output serial_format,
      output in_single_line,
      output out_single_line,
      input deemph_mode,
      input in_frame_format,
      input out_frame_format
   );

   modport dec (
      input deemph_enable,
      input serial_format,
      input in_single_line,
      input out_single_line,
      output deemph_mode,
      output in_frame_format,
      output out_frame_format
   );
endinterface

//--- ccrb_mode_decode.sv
/*
 * mode decoder: resolves the de-emphasis rate and the framing of each port.
 * assumes: detected rate and forced-lock level come from the clock block.
 */
`timescale 1ns/1ps
module ccrb_mode_decode (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic force_loop_lock,
   input wire logic [1:0] deemph_rate,
   input wire logic [1:0] detected_rate,
   ccrb_mode_if.dec mode
);

   function automatic ccrb_pkg::ccrb_fmt_t frame_of(input logic [1:0] line,
                                                  input logic [1:0] general);
      case (line)
         ccrb_pkg::LINE_GENERAL: begin
            case (general)
               ccrb_pkg::SER_LEFT: frame_of = ccrb_pkg::FMT_LEFT;
               ccrb_pkg::SER_I2S: frame_of = ccrb_pkg::FMT_I2S;
               ccrb_pkg::SER_RIGHT: frame_of = ccrb_pkg::FMT_RIGHT;
               default: frame_of = ccrb_pkg::FMT_RSVD;
            endcase
         end
         ccrb_pkg::LINE_ONE: frame_of = ccrb_pkg::FMT_LINE_ONE;
         ccrb_pkg::LINE_TWO: frame_of = ccrb_pkg::FMT_LINE_TWO;
         default: frame_of = ccrb_pkg::FMT_RSVD;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // detected codes other than the three rates already read as none
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mode.deemph_mode <= ccrb_pkg::DE_NONE;
      end else if (!mode.deemph_enable) begin
         mode.deemph_mode <= ccrb_pkg::DE_NONE;
      end else if (force_loop_lock) begin
         mode.deemph_mode <= ccrb_pkg::ccrb_deemph_t'(deemph_rate);
      end else begin
         mode.deemph_mode <= ccrb_pkg::ccrb_deemph_t'(detected_rate);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mode.in_frame_format <= ccrb_pkg::FMT_I2S;
         mode.out_frame_format <= ccrb_pkg::FMT_I2S;
      end else begin
         mode.in_frame_format <= frame_of(mode.in_single_line, mode.serial_format);
         mode.out_frame_format <= frame_of(mode.out_single_line, mode.serial_format);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   property p_deemph_off;
      @(posedge clk) disable iff (!rst_n)
      !mode.deemph_enable |=> mode.deemph_mode == ccrb_pkg::DE_NONE;
   endproperty
   a_deemph_off: assert property (p_deemph_off) else $error("de-emphasis on while disabled");

   property p_deemph_forced;
      @(posedge clk) disable iff (!rst_n)
      mode.deemph_enable && force_loop_lock |=> mode.deemph_mode == $past(deemph_rate);
   endproperty
   a_deemph_forced: assert property (p_deemph_forced) else $error("forced rate not used");

endmodule

//--- ccrb_bank.sv
/*
 * codec control register bank: address pointer with auto-increment, read-only
 * identity register and the power, functional mode, interface format and
 * misc control registers, with their fields driven out as levels.
 * assumes: a byte-level control port front end delivers start, write bytes
 * and read requests synchronous to clk; clock block supplies the rate inputs.
 */
// Overview of operation
// - all registers here writable except identity register, which is read only
// - every register bit loads its default on reset
// - pointer byte bit 7 enables auto-increment after each access; default set
// - pointer byte low 7 bits select the accessed register; default 01h
// - register 01h holds part code high nibble, silicon level low nibble
// - power bit 6 holds the loop in reset; change only when muted
// - power bit 5 holds the input converter in reset
// - power bits 3..1 each hold one output pair in reset; default clear
// - power bit 0 defaults set, sleeping whole device; host clears it
// - 03h bits 7:6 give output port speed range; 11 reserved
// - 03h bits 5:4 give input port speed range, same codes
// - 03h bit 2 picks which port clocks the converter serial output
// - without forced lock, de-emphasis only when enabled and detected rate is 32, 44.1 or 48k
// - with forced lock, de-emphasis rate comes from the separate rate field
// - 04h bits 7:6 general serial format, default I2S
// - 04h bits 5:4 input port framing: general, line one or two
// - 04h bits 3:2 output port framing, same codes
// - 04h bit 0 picks 16-bit right-justified words, else 24
// - 05h carries clock source, tristate, freeze, filter, hold, master selects
`timescale 1ns/1ps
module ccrb_bank #(
   parameter logic [3:0] PART_CODE = 4'h9, // arbitrary value
   parameter logic [3:0] SILICON_LEVEL = 4'h1 // arbitrary value
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic cp_start,
   input wire logic cp_wr_valid,
   input wire logic [7:0] cp_wr_data,
   input wire logic cp_rd_req,
   output logic [7:0] cp_rd_data,
   output logic cp_rd_valid,
   input wire logic force_loop_lock,
   input wire logic [1:0] deemph_rate,
   input wire logic [1:0] detected_rate,
   output logic pll_sleep,
   output logic in_conv_sleep,
   output logic [2:0] out_pair_sleep,
   output logic global_sleep,
   output logic [1:0] out_speed_range,
   output logic [1:0] in_speed_range,
   output logic in_serial_out,
   output logic rj_short_word,
   output logic ext_sclk_from_out,
   output logic recovered_clk_tristate,
   output logic freeze,
   output logic interp_rolloff_pick,
   output logic highpass_hold,
   output logic out_serial_port,
   output logic in_serial_port,
   output logic [1:0] deemph_mode,
   output logic [2:0] in_frame_format,
   output logic [2:0] out_frame_format
);

   ccrb_pkg::ccrb_cp_state_t cp_state;
   logic [6:0] pointer;
   logic pointer_autoinc;
   logic [7:0] power_control;
   logic [7:0] functional_mode;
   logic [7:0] interface_formats;
   logic [7:0] misc_control;
   logic ptr_phase;
   logic wr_ptr;
   logic wr_reg;
   logic rd_acc;

   ccrb_mode_if mode ();

   ////////////////////////////////////////////////////////////////////////////
   // writable mask per address; zero marks read-only or unmapped
   function automatic logic [7:0] write_mask(input logic [6:0] addr);
      case (addr)
         ccrb_pkg::ADDR_POWER: write_mask = ccrb_pkg::POWER_MASK;
         ccrb_pkg::ADDR_FMODE: write_mask = ccrb_pkg::FMODE_MASK;
         ccrb_pkg::ADDR_IFMT: write_mask = ccrb_pkg::IFMT_MASK;
         ccrb_pkg::ADDR_MISC: write_mask = ccrb_pkg::MISC_MASK;
         default: write_mask = 8'h00;
      endcase
   endfunction

   function automatic logic [7:0] read_mux(input logic [6:0] addr,
                                          input logic [7:0] pwr,
                                          input logic [7:0] fm,
                                          input logic [7:0] ifm,
                                          input logic [7:0] misc);
      case (addr)
         ccrb_pkg::ADDR_IDENT: read_mux = {PART_CODE, SILICON_LEVEL};
         ccrb_pkg::ADDR_POWER: read_mux = pwr;
         ccrb_pkg::ADDR_FMODE: read_mux = fm;
         ccrb_pkg::ADDR_IFMT: read_mux = ifm;
         ccrb_pkg::ADDR_MISC: read_mux = misc;
         default: read_mux = 8'h00;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // a start makes the same-cycle write byte the pointer byte
   assign ptr_phase = cp_start || (cp_state == ccrb_pkg::CP_POINTER);
   assign wr_ptr = cp_wr_valid && ptr_phase;
   assign wr_reg = cp_wr_valid && !ptr_phase;
   // one access per cycle: a write shadows a read request
   assign rd_acc = cp_rd_req && !cp_wr_valid;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cp_state <= ccrb_pkg::CP_POINTER;
      end else begin
         case (cp_state)
            ccrb_pkg::CP_POINTER: begin
               if (wr_ptr) begin
                  cp_state <= ccrb_pkg::CP_DATA;
               end
            end
            ccrb_pkg::CP_DATA: begin
               if (wr_ptr) begin
                  cp_state <= ccrb_pkg::CP_DATA;
               end else if (cp_start) begin
                  cp_state <= ccrb_pkg::CP_POINTER;
               end
            end
            default: cp_state <= ccrb_pkg::CP_POINTER;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pointer <= ccrb_pkg::PTR_RESET;
         pointer_autoinc <= ccrb_pkg::PTR_AUTOINC_RESET;
      end else if (wr_ptr) begin
         pointer <= cp_wr_data[6:0];
         pointer_autoinc <= cp_wr_data[ccrb_pkg::PTR_AUTOINC_BIT];
      end else if ((wr_reg || rd_acc) && pointer_autoinc) begin
         pointer <= pointer + 7'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // reserved bits are stored as zero so they read back as zero
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         power_control <= ccrb_pkg::POWER_RESET;
         functional_mode <= ccrb_pkg::FMODE_RESET;
         interface_formats <= ccrb_pkg::IFMT_RESET;
         misc_control <= ccrb_pkg::MISC_RESET;
      end else if (wr_reg) begin
         case (pointer)
            ccrb_pkg::ADDR_POWER: power_control <= cp_wr_data & write_mask(pointer);
            ccrb_pkg::ADDR_FMODE: functional_mode <= cp_wr_data & write_mask(pointer);
            ccrb_pkg::ADDR_IFMT: interface_formats <= cp_wr_data & write_mask(pointer);
            ccrb_pkg::ADDR_MISC: misc_control <= cp_wr_data & write_mask(pointer);
            default: power_control <= power_control;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cp_rd_data <= 8'h00;
         cp_rd_valid <= 1'b0;
      end else begin
         cp_rd_valid <= rd_acc;
         if (rd_acc) begin
            cp_rd_data <= read_mux(pointer, power_control, functional_mode,
                                   interface_formats, misc_control);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // field outputs: each is one or more flop bits of its register
   assign pll_sleep = power_control[ccrb_pkg::PLL_SLEEP_BIT];
   assign in_conv_sleep = power_control[ccrb_pkg::IN_CONV_SLEEP_BIT];
   assign out_pair_sleep = power_control[ccrb_pkg::OUT_PAIR_LSB +: 3];
   assign global_sleep = power_control[ccrb_pkg::GLOBAL_SLEEP_BIT];
   assign out_speed_range = functional_mode[ccrb_pkg::OUT_SPEED_LSB +: 2];
   assign in_speed_range = functional_mode[ccrb_pkg::IN_SPEED_LSB +: 2];
   assign in_serial_out = functional_mode[ccrb_pkg::IN_SERIAL_OUT_BIT];
   assign rj_short_word = interface_formats[ccrb_pkg::RJ_SHORT_BIT];
   assign ext_sclk_from_out = misc_control[ccrb_pkg::EXT_SCLK_BIT];
   assign recovered_clk_tristate = misc_control[ccrb_pkg::RCLK_TRI_BIT];
   assign freeze = misc_control[ccrb_pkg::FREEZE_BIT];
   assign interp_rolloff_pick = misc_control[ccrb_pkg::INTERP_BIT];
   assign highpass_hold = misc_control[ccrb_pkg::HPF_HOLD_BIT];
   assign out_serial_port = misc_control[ccrb_pkg::OUT_MASTER_BIT];
   assign in_serial_port = misc_control[ccrb_pkg::IN_MASTER_BIT];

   assign mode.deemph_enable = functional_mode[ccrb_pkg::DEEMPH_EN_BIT];
   assign mode.serial_format = interface_formats[ccrb_pkg::FORMAT_LSB +: 2];
   assign mode.in_single_line = interface_formats[ccrb_pkg::IN_LINE_LSB +: 2];
   assign mode.out_single_line = interface_formats[ccrb_pkg::OUT_LINE_LSB +: 2];

   // decoded modes lag the register by one cycle
   ccrb_mode_decode u_decode (
      .clk(clk),
      .rst_n(rst_n),
      .force_loop_lock(force_loop_lock),
      .deemph_rate(deemph_rate),
      .detected_rate(detected_rate),
      .mode(mode.dec)
   );

   assign deemph_mode = mode.deemph_mode;
   assign in_frame_format = mode.in_frame_format;
   assign out_frame_format = mode.out_frame_format;

   ////////////////////////////////////////////////////////////////////////////
   sequence s_read_ident;
      rd_acc && pointer == ccrb_pkg::ADDR_IDENT;
   endsequence

   sequence s_power_write;
      wr_reg && pointer == ccrb_pkg::ADDR_POWER;
   endsequence

   property p_ident_read;
      @(posedge clk) disable iff (!rst_n)
      s_read_ident |=> cp_rd_valid && cp_rd_data == {PART_CODE, SILICON_LEVEL};
   endproperty
   a_ident_read: assert property (p_ident_read) else $error("bad identity read");

   property p_autoinc;
      @(posedge clk) disable iff (!rst_n)
      (wr_reg || rd_acc) && pointer_autoinc |=> pointer == $past(pointer) + 7'h01;
   endproperty
   a_autoinc: assert property (p_autoinc) else $error("pointer did not advance");

   property p_no_autoinc;
      @(posedge clk) disable iff (!rst_n)
      (wr_reg || rd_acc) && !pointer_autoinc |=> $stable(pointer);
   endproperty
   a_no_autoinc: assert property (p_no_autoinc) else $error("pointer moved");

   property p_ptr_load;
      @(posedge clk) disable iff (!rst_n)
      wr_ptr |=> pointer == $past(cp_wr_data[6:0]) && cp_state == ccrb_pkg::CP_DATA;
   endproperty
   a_ptr_load: assert property (p_ptr_load) else $error("pointer byte not taken");

   property p_ro_write;
      @(posedge clk) disable iff (!rst_n)
      wr_reg && write_mask(pointer) == 8'h00 |=>
         $stable(power_control) && $stable(functional_mode)
         && $stable(interface_formats) && $stable(misc_control);
   endproperty
   a_ro_write: assert property (p_ro_write) else $error("read-only write stored");

   property p_reserved_zero;
      @(posedge clk) disable iff (!rst_n)
      (power_control & ~ccrb_pkg::POWER_MASK) == 8'h00
      && (functional_mode & ~ccrb_pkg::FMODE_MASK) == 8'h00
      && (interface_formats & ~ccrb_pkg::IFMT_MASK) == 8'h00
      && (misc_control & ~ccrb_pkg::MISC_MASK) == 8'h00;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

   property p_power_fields;
      @(posedge clk) disable iff (!rst_n)
      s_power_write |=> pll_sleep == $past(cp_wr_data[6]) && in_conv_sleep == $past(cp_wr_data[5])
         && out_pair_sleep == $past(cp_wr_data[3:1]) && global_sleep == $past(cp_wr_data[0]);
   endproperty
   a_power_fields: assert property (p_power_fields) else $error("power field mismatch");

   property p_read_latency;
      @(posedge clk) disable iff (!rst_n)
      rd_acc |=> cp_rd_valid ##1 !cp_rd_valid || $past(rd_acc);
   endproperty
   a_read_latency: assert property (p_read_latency) else $error("read answer timing");

   property p_frame_follows;
      @(posedge clk) disable iff (!rst_n)
      mode.in_single_line == ccrb_pkg::LINE_ONE ##1
         mode.in_single_line == ccrb_pkg::LINE_ONE |-> in_frame_format == ccrb_pkg::FMT_LINE_ONE;
   endproperty
   a_frame_follows: assert property (p_frame_follows) else $error("input framing wrong");

endmodule

//--- ccrb_host_model.sv
/*
 * host model: drives the byte-level control port strobes of the register bank
 * and collects every read byte that the bank answers.
 * assumes: one clock; strobes change at the falling edge only.
 */
`timescale 1ns/1ps
module ccrb_host_model (
   input wire logic clk,
   output logic cp_start,
   output logic cp_wr_valid,
   output logic [7:0] cp_wr_data,
   output logic cp_rd_req,
   input wire logic [7:0] cp_rd_data,
   input wire logic cp_rd_valid
);
   logic [7:0] rd_q[$];

   initial begin
      cp_start = 1'b0;
      cp_wr_valid = 1'b0;
      cp_wr_data = 8'h00;
      cp_rd_req = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // one request per falling edge, held across the next rising edge
   task automatic drive(input logic s, input logic w, input logic [7:0] d, input logic r);
      @(negedge clk);
      cp_start = s;
      cp_wr_valid = w;
      cp_wr_data = d;
      cp_rd_req = r;
   endtask

   // released data bus shows the inverse so stale values never match
   task automatic idle();
      drive(1'b0, 1'b0, ~cp_wr_data, 1'b0);
   endtask

   // address goes in bits 6:0, auto-increment in bit 7
   task automatic ptr(input logic ai, input logic [6:0] a);
      drive(1'b1, 1'b1, {ai, a}, 1'b0);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   always @(posedge clk) begin
      if (cp_rd_valid === 1'b1) begin
         rd_q.push_back(cp_rd_data);
      end
   end
endmodule

//--- tb_codec_control_register_bank.sv
/*
 * self-checking bench of the register bank: reset values, read-back with
 * masking, pointer modes, de-emphasis and framing decode.
 * assumes: host model drives the control port; bench drives rate inputs.
 */
`timescale 1ns/1ps
module tb_codec_control_register_bank;
   localparam logic [3:0] PART = 4'h6; // arbitrary value
   localparam logic [3:0] SIL = 4'h2; // arbitrary value
   logic clk, rst_n, cp_start, cp_wr_valid, cp_rd_req, cp_rd_valid;
   logic [7:0] cp_wr_data, cp_rd_data, v, mem[1:5];
   logic force_loop_lock, pll_sleep, in_conv_sleep, global_sleep, in_serial_out;
   logic rj_short_word, ext_sclk_from_out, recovered_clk_tristate, freeze;
   logic interp_rolloff_pick, highpass_hold, out_serial_port, in_serial_port;
   logic [1:0] deemph_rate, detected_rate, out_speed_range, in_speed_range, deemph_mode;
   logic [2:0] out_pair_sleep, in_frame_format, out_frame_format;
   logic [15:0] seed;
   int error_cnt, n_tests;

   ccrb_bank #(.PART_CODE(PART), .SILICON_LEVEL(SIL)) DUT (.clk(clk), .rst_n(rst_n),
      .cp_start(cp_start), .cp_wr_valid(cp_wr_valid), .cp_wr_data(cp_wr_data),
      .cp_rd_req(cp_rd_req), .cp_rd_data(cp_rd_data), .cp_rd_valid(cp_rd_valid),
      .force_loop_lock(force_loop_lock), .deemph_rate(deemph_rate),
      .detected_rate(detected_rate), .pll_sleep(pll_sleep), .in_conv_sleep(in_conv_sleep),
      .out_pair_sleep(out_pair_sleep), .global_sleep(global_sleep),
      .out_speed_range(out_speed_range), .in_speed_range(in_speed_range),
      .in_serial_out(in_serial_out), .rj_short_word(rj_short_word),
      .ext_sclk_from_out(ext_sclk_from_out), .recovered_clk_tristate(recovered_clk_tristate),
      .freeze(freeze), .interp_rolloff_pick(interp_rolloff_pick),
      .highpass_hold(highpass_hold), .out_serial_port(out_serial_port),
      .in_serial_port(in_serial_port), .deemph_mode(deemph_mode),
      .in_frame_format(in_frame_format), .out_frame_format(out_frame_format));
   ccrb_host_model host (.clk(clk), .cp_start(cp_start), .cp_wr_valid(cp_wr_valid),
      .cp_wr_data(cp_wr_data), .cp_rd_req(cp_rd_req), .cp_rd_data(cp_rd_data),
      .cp_rd_valid(cp_rd_valid));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [7:0] rnd();
      seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
      return seed[7:0];
   endfunction

   // writable bits; reserved positions stay zero
   function automatic logic [7:0] mask(input logic [6:0] a);
      case (a)
         7'h02: return 8'h6f;
         7'h03: return 8'hf6;
         7'h04: return 8'hfd;
         7'h05: return 8'hdf;
         default: return 8'h00;
      endcase
   endfunction

   function automatic logic [7:0] exp_rd(input logic [6:0] a);
      if (a == 7'h01) return {PART, SIL};
      if (a >= 7'h02 && a <= 7'h05) return mem[a];
      return 8'h00;
   endfunction

   function automatic logic [2:0] fmt_exp(input logic [1:0] g, input logic [1:0] l);
      if (l == 2'b01) return 3'b011;
      if (l == 2'b10) return 3'b100;
      if (l == 2'b11 || g == 2'b11) return 3'b111;
      return {1'b0, g};
   endfunction

   function automatic logic [1:0] de_exp(input logic en, input logic f, input logic [1:0] r,
                                         input logic [1:0] d);
      if (!en) return 2'b00;
      return f ? r : d;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic complete_run();
      $display("errors=%0d checks=%0d", error_cnt, n_tests);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      host.drive(1'b0, 1'b1, d, 1'b0);
      mem[a] = (a >= 7'h02 && a <= 7'h05) ? d & mask(a) : 8'h00;
   endtask

   task automatic pop_chk(input logic [6:0] a);
      for (int k = 0; k < 8 && host.rd_q.size() == 0; k++) @(posedge clk);
      if (host.rd_q.size() == 0) begin
         error_cnt++;
         complete_run();
      end else begin
         check(host.rd_q.pop_front(), exp_rd(a));
      end
   endtask

   task automatic rd_burst(input logic [6:0] a, input int n);
      host.ptr(1'b1, a);
      for (int i = 0; i < n; i++) host.drive(1'b0, 1'b0, rnd(), 1'b1);
      host.idle();
      for (int i = 0; i < n; i++) pop_chk(a + 7'(i));
   endtask

   task automatic chk_fields();
      repeat (3) @(posedge clk);
      @(negedge clk);
      check({2'h0, pll_sleep, in_conv_sleep, out_pair_sleep, global_sleep},
            {2'h0, mem[2][6:5], mem[2][3:0]});
      check({3'h0, out_speed_range, in_speed_range, in_serial_out},
            {3'h0, mem[3][7:4], mem[3][2]});
      check({7'h0, rj_short_word}, {7'h0, mem[4][0]});
      check({ext_sclk_from_out, recovered_clk_tristate, freeze, interp_rolloff_pick,
             highpass_hold, out_serial_port, in_serial_port, 1'b0},
            {mem[5][7:6], mem[5][4:0], 1'b0});
      check({2'h0, in_frame_format, out_frame_format},
            {2'h0, fmt_exp(mem[4][7:6], mem[4][5:4]), fmt_exp(mem[4][7:6], mem[4][3:2])});
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      rst_n = 1'b0;
      force_loop_lock = 1'b0;
      deemph_rate = 2'b00;
      detected_rate = 2'b00;
      seed = 16'h3987;
      error_cnt = 0;
      n_tests = 0;
      mem[1] = 8'h00;
      mem[2] = 8'h01;
      mem[3] = 8'h00;
      mem[4] = 8'h40;
      mem[5] = 8'h00;
      repeat (10) @(posedge clk);
      @(negedge clk);
      rst_n = 1'b1;
      chk_fields();
      rd_burst(7'h01, 5);
      repeat (20) begin
         host.ptr(1'b1, 7'h01);
         for (int a = 1; a <= 5; a++) wr(7'(a), rnd());
         host.idle();
         chk_fields();
         rd_burst(7'h01, 6);
         host.ptr(1'b0, 7'h03);
         wr(7'h03, rnd());
         wr(7'h03, rnd());
         host.drive(1'b0, 1'b0, rnd(), 1'b1);
         host.drive(1'b0, 1'b0, rnd(), 1'b1);
         host.idle();
         pop_chk(7'h03);
         pop_chk(7'h03);
      end
      for (int i = 0; i < 16; i++) begin
         @(negedge clk);
         force_loop_lock = i[2];
         deemph_rate = i[1:0];
         detected_rate = 2'(rnd());
         host.ptr(1'b0, 7'h03);
         wr(7'h03, {rnd() & 8'hfd} | {6'h00, i[3], 1'b0});
         host.idle();
         repeat (3) @(posedge clk);
         @(negedge clk);
         check({6'h0, deemph_mode},
               {6'h0, de_exp(i[3], i[2], i[1:0], detected_rate)});
      end
      for (int i = 0; i < 64; i++) begin
         host.ptr(1'b0, 7'h04);
         v = rnd();
         wr(7'h04, {i[5:0], v[1:0]});
         host.idle();
         chk_fields();
      end
      host.ptr(1'b1, 7'h02);
      host.drive(1'b1, 1'b0, rnd(), 1'b0);
      host.drive(1'b0, 1'b1, 8'h85, 1'b0);
      v = rnd();
      host.drive(1'b0, 1'b1, v, 1'b1);
      mem[5] = v & mask(7'h05);
      host.idle();
      repeat (3) @(posedge clk);
      check(8'(host.rd_q.size()), 8'h00);
      rd_burst(7'h05, 1);
      complete_run();
   end
endmodule
